// file: hdl/sea_array_access.sv
`timescale 1ns/1ps
module sea_array_access #(
  parameter int unsigned WRITE_CYCLES = sea_pkg::WRITE_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_SCK,
  input wire logic I_CS_N,
  input wire logic I_MOSI,
  input wire logic I_BLOCK_PROTECT_HI,
  input wire logic I_BLOCK_PROTECT_LO,
  input wire logic I_WEL_SET,
  input wire logic I_WEL_CLR,
  input wire logic I_STATUS_WRITE_BUSY,
  output logic O_MISO,
  output logic O_MISO_OE,
  output logic O_WRITE_IN_PROGRESS,
  output logic O_WRITE_ENABLE_LATCH
);

  // ==========================================================
  // storage
  // array: written on I_CLK, read on both clocks; the link only
  // reads while no write cycle runs, so the ports never collide
  sea_pkg::sea_word_t mem_q [0:sea_pkg::WORDS-1];
  // page buffer: filled on I_SCK, drained on I_CLK after select rose
  logic [7:0] buf_q [0:255];

  // ==========================================================
  // link side signals
  logic spi_rst;
  sea_pkg::sea_link_state_t lnk_q;
  logic [2:0] bit_q;
  logic [1:0] abyte_q;
  logic [7:0] sh_q;
  logic op_read_q;
  logic [sea_pkg::ADDR_W-1:0] addr_q;
  logic [7:0] in_byte;
  logic byte_end;
  logic addr_done;
  logic [sea_pkg::ADDR_W-1:0] new_addr;
  logic wr_byte_ok;
  logic busy_s1_q;
  logic busy_s2_q;
  sea_pkg::sea_frame_t frm_q;
  sea_pkg::sea_word_t rd_word;
  logic [31:0] rd_data;
  logic [7:0] rd_byte;
  logic [7:0] miso_sh_q;
  logic oe_q;

  // ==========================================================
  // system side signals
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic cs_rise;
  logic busy_q;
  logic write_in_progress;
  logic wel_q;
  logic prot_hit;
  logic commit;
  sea_pkg::sea_prog_state_t prg_q;
  logic [sea_pkg::GROUP_W-1:0] grp_q;
  logic [8:0] page_q;
  logic [7:0] start_q;
  logic [8:0] cnt_q;
  logic [31:0] merged_q;
  logic [31:0] tmr_q;
  logic tmr_end;
  logic [3:0] byte_vld;
  logic touched;
  logic last_grp;
  logic [sea_pkg::WORD_IDX_W-1:0] prg_idx;
  sea_pkg::sea_word_t old_word;
  logic [31:0] old_data;
  logic [31:0] merged;
  logic mem_we;
  sea_pkg::sea_word_t mem_wdata;

  // ==========================================================
  // delivery contents
  // array holds all ones with matching check bits at start
  initial begin
    for (int i = 0; i < sea_pkg::WORDS; i++) begin
      mem_q[i] = '{check: sea_pkg::ecc_check(sea_pkg::DELIVERY_WORD),
                   data: sea_pkg::DELIVERY_WORD};
    end
  end

  // ==========================================================
  // link: bit and byte framing
  // select high holds the link logic in reset, so any rising
  // edge of select ends the frame whatever bit it is in
  assign spi_rst = I_RST | I_CS_N;
  assign in_byte = {sh_q[6:0], I_MOSI};
  assign byte_end = (bit_q == sea_pkg::LAST_BIT);
  assign addr_done = (lnk_q == sea_pkg::LNK_ADDR) && byte_end &&
                     (abyte_q == sea_pkg::LAST_ADDR_BYTE);
  assign new_addr = sea_pkg::ADDR_W'({addr_q, in_byte});
  assign wr_byte_ok = (lnk_q == sea_pkg::LNK_WRITE) && byte_end;

  // bit counter and input shifter, sampled on rising clock
  always_ff @(posedge I_SCK or posedge spi_rst) begin
    if (spi_rst) begin
      bit_q <= 3'h0;
      sh_q <= 8'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q <= in_byte;
    end
  end

  // busy level into the link clock; stale for two edges at most,
  // which the opcode byte always covers
  always_ff @(posedge I_SCK or posedge I_RST) begin
    if (I_RST) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= write_in_progress;
      busy_s2_q <= busy_s1_q;
    end
  end

  // ==========================================================
  // link: instruction decode
  always_ff @(posedge I_SCK or posedge spi_rst) begin
    if (spi_rst) begin
      lnk_q <= sea_pkg::LNK_CMD;
      op_read_q <= 1'b0;
      abyte_q <= 2'h0;
    end else begin
      case (lnk_q)
        sea_pkg::LNK_CMD: begin
          if (byte_end) begin
            if (busy_s2_q) begin
              lnk_q <= sea_pkg::LNK_IGNORE;
            end else if (in_byte == sea_pkg::OP_READ) begin
              lnk_q <= sea_pkg::LNK_ADDR;
              op_read_q <= 1'b1;
            end else if (in_byte == sea_pkg::OP_WRITE) begin
              lnk_q <= sea_pkg::LNK_ADDR;
              op_read_q <= 1'b0;
            end else begin
              lnk_q <= sea_pkg::LNK_IGNORE;
            end
          end
        end
        sea_pkg::LNK_ADDR: begin
          if (byte_end) begin
            abyte_q <= abyte_q + 2'h1;
          end
          if (addr_done) begin
            lnk_q <= op_read_q ? sea_pkg::LNK_READ : sea_pkg::LNK_WRITE;
          end
        end
        sea_pkg::LNK_READ: lnk_q <= sea_pkg::LNK_READ;
        sea_pkg::LNK_WRITE: lnk_q <= sea_pkg::LNK_WRITE;
        sea_pkg::LNK_IGNORE: lnk_q <= sea_pkg::LNK_IGNORE;
        default: lnk_q <= sea_pkg::LNK_IGNORE;
      endcase
    end
  end

  // ==========================================================
  // link: address counter
  always_ff @(posedge I_SCK or posedge spi_rst) begin
    if (spi_rst) begin
      addr_q <= '0;
    end else if (lnk_q == sea_pkg::LNK_ADDR && byte_end) begin
      addr_q <= new_addr;
    end else if (lnk_q == sea_pkg::LNK_READ && byte_end) begin
      addr_q <= addr_q + 17'h00001;
    end else if (wr_byte_ok) begin
      addr_q[7:0] <= addr_q[7:0] + 8'h01;
    end
  end

  // ==========================================================
  // link: page buffer fill
  // buffer index is the in-page address, so overflow bytes land
  // on the page start and the latest value wins
  always_ff @(posedge I_SCK) begin
    if (wr_byte_ok) begin
      buf_q[addr_q[7:0]] <= in_byte;
    end
  end

  // ==========================================================
  // link: frame result for the write engine
  // not reset by select, so it survives the rising edge; armed
  // is true only when the last edge closed a data byte
  always_ff @(posedge I_SCK or posedge I_RST) begin
    if (I_RST) begin
      frm_q <= '0;
    end else begin
      frm_q.armed <= wr_byte_ok;
      if (addr_done && !op_read_q) begin
        frm_q.start <= new_addr;
        frm_q.count <= 9'h000;
      end else if (wr_byte_ok && frm_q.count != sea_pkg::PAGE_BYTES) begin
        frm_q.count <= frm_q.count + 9'h001;
      end
    end
  end

  // ==========================================================
  // link: read data out
  sea_ecc_fix u_rd_fix (
    .i_word(rd_word),
    .o_data(rd_data)
  );

  assign rd_word = mem_q[addr_q[sea_pkg::ADDR_W-1:2]];
  assign rd_byte = rd_data[{addr_q[1:0], 3'h0} +: 8];

  // output changes on the falling clock; a new byte is loaded
  // whenever the bit counter has just wrapped to zero
  always_ff @(negedge I_SCK or posedge spi_rst) begin
    if (spi_rst) begin
      miso_sh_q <= 8'h00;
      oe_q <= 1'b0;
    end else if (lnk_q == sea_pkg::LNK_READ) begin
      oe_q <= 1'b1;
      if (bit_q == 3'h0) begin
        miso_sh_q <= rd_byte;
      end else begin
        miso_sh_q <= {miso_sh_q[6:0], 1'b0};
      end
    end
  end

  assign O_MISO = miso_sh_q[7];
  assign O_MISO_OE = oe_q;

  // ==========================================================
  // system: select synchroniser and rising edge
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= I_CS_N;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  assign cs_rise = cs_s2_q & ~cs_s3_q;

  // ==========================================================
  // system: acceptance of a write
  // protected area from the two outside protection bits
  always_comb begin
    case ({I_BLOCK_PROTECT_HI, I_BLOCK_PROTECT_LO})
      sea_pkg::BP_QUARTER: prot_hit = (frm_q.start[16:15] ==
                                       sea_pkg::TOP_QUARTER);
      sea_pkg::BP_HALF: prot_hit = frm_q.start[16];
      sea_pkg::BP_ALL: prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  end

  // frame result is read only after select rose and the link
  // clock has stopped, so it is steady when sampled here
  assign commit = cs_rise && frm_q.armed && wel_q && !busy_q &&
                  !prot_hit;

  // write enable latch: a set from the status logic wins
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      wel_q <= 1'b0;
    end else if (I_WEL_SET) begin
      wel_q <= 1'b1;
    end else if (I_WEL_CLR || (prg_q == sea_pkg::PRG_HOLD && tmr_end)) begin
      wel_q <= 1'b0;
    end
  end

  // ==========================================================
  // system: self-timed write cycle
  assign tmr_end = (tmr_q == 32'(WRITE_CYCLES - 1));
  assign last_grp = (grp_q == sea_pkg::LAST_GROUP);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      busy_q <= 1'b0;
      tmr_q <= 32'h00000000;
    end else if (commit) begin
      busy_q <= 1'b1;
      tmr_q <= 32'h00000000;
    end else if (prg_q == sea_pkg::PRG_HOLD && tmr_end) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      tmr_q <= tmr_q + 32'h00000001;
    end
  end

  // status write cycles also count as busy for the link
  assign write_in_progress = busy_q | I_STATUS_WRITE_BUSY;
  assign O_WRITE_IN_PROGRESS = write_in_progress;
  assign O_WRITE_ENABLE_LATCH = wel_q;

  // captured copy of the frame so a later write frame cannot move it
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      page_q <= 9'h000;
      start_q <= 8'h00;
      cnt_q <= 9'h000;
    end else if (commit) begin
      page_q <= frm_q.start[sea_pkg::ADDR_W-1:sea_pkg::PAGE_W];
      start_q <= frm_q.start[7:0];
      cnt_q <= frm_q.count;
    end
  end

  // per byte of the current group: was it sent, and new content
  assign prg_idx = {page_q, grp_q};
  assign old_word = mem_q[prg_idx];

  sea_ecc_fix u_old_fix (
    .i_word(old_word),
    .o_data(old_data)
  );

  for (genvar k = 0; k < 4; k++) begin : g_merge
    logic [7:0] pos;
    logic [7:0] off;
    assign pos = {grp_q, 2'(k)};
    assign off = pos - start_q;
    assign byte_vld[k] = {1'b0, off} < cnt_q;
    // unsent bytes of a touched group are rewritten unchanged
    assign merged[8*k +: 8] = byte_vld[k] ? buf_q[pos] :
                              old_data[8*k +: 8];
  end

  assign touched = |byte_vld;

  // walk the page one group at a time: erase, then program;
  // the hold state pads the cycle to its fixed length
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      prg_q <= sea_pkg::PRG_IDLE;
      grp_q <= '0;
      merged_q <= 32'h00000000;
    end else begin
      case (prg_q)
        sea_pkg::PRG_IDLE: begin
          grp_q <= '0;
          if (commit) begin
            prg_q <= sea_pkg::PRG_ERASE;
          end
        end
        sea_pkg::PRG_ERASE: begin
          if (touched) begin
            merged_q <= merged;
            prg_q <= sea_pkg::PRG_PROG;
          end else if (last_grp) begin
            prg_q <= sea_pkg::PRG_HOLD;
          end else begin
            grp_q <= grp_q + 6'h01;
          end
        end
        sea_pkg::PRG_PROG: begin
          if (last_grp) begin
            prg_q <= sea_pkg::PRG_HOLD;
          end else begin
            grp_q <= grp_q + 6'h01;
            prg_q <= sea_pkg::PRG_ERASE;
          end
        end
        sea_pkg::PRG_HOLD: begin
          if (tmr_end) begin
            prg_q <= sea_pkg::PRG_IDLE;
          end
        end
        default: prg_q <= sea_pkg::PRG_IDLE;
      endcase
    end
  end

  // ==========================================================
  // system: array write port
  // erased cells read zero; the check bits of zero are zero, so
  // an erased group is itself a valid code word
  assign mem_we = (prg_q == sea_pkg::PRG_ERASE && touched) ||
                  (prg_q == sea_pkg::PRG_PROG);

  always_comb begin
    if (prg_q == sea_pkg::PRG_PROG) begin
      mem_wdata.data = merged_q;
      mem_wdata.check = sea_pkg::ecc_check(merged_q);
    end else begin
      mem_wdata.data = sea_pkg::ERASED_WORD;
      mem_wdata.check = sea_pkg::ecc_check(sea_pkg::ERASED_WORD);
    end
  end

  // array is nonvolatile: reset leaves its contents alone
  always @(posedge I_CLK) begin
    if (mem_we) begin
      mem_q[prg_idx] <= mem_wdata;
    end
  end

endmodule : sea_array_access

// file: hdl/sea_ecc_fix.sv
`timescale 1ns/1ps
// ==========================================================
// corrects one flipped data bit of a stored group
module sea_ecc_fix (
  input wire sea_pkg::sea_word_t i_word,
  output logic [31:0] o_data
);

  logic [5:0] syn;

  // syndrome equals the position of a single bad data bit
  assign syn = sea_pkg::ecc_check(i_word.data) ^ i_word.check;

  // a check bit error gives a power of two and touches no data
  for (genvar j = 0; j < 32; j++) begin : g_fix
    assign o_data[j] = i_word.data[j] ^ (syn == sea_pkg::ecc_pos(j));
  end

endmodule : sea_ecc_fix

// file: hdl/sea_pkg.sv
package sea_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W = 17;
  localparam int WORDS = 32768;
  localparam int WORD_IDX_W = 15;
  localparam int PAGE_W = 8;
  localparam int GROUP_W = 6;
  localparam logic [5:0] LAST_GROUP = 6'h3F;
  localparam logic [8:0] PAGE_BYTES = 9'h100;

  // ==========================================================
  // instruction set
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ==========================================================
  // contents
  localparam logic [31:0] DELIVERY_WORD = 32'hFFFFFFFF;
  localparam logic [31:0] ERASED_WORD = 32'h00000000;

  // ==========================================================
  // protection codes of {hi, lo}
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [1:0] TOP_QUARTER = 2'h3;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_TIME_NS = 4000000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================
  // types
  typedef struct packed {
    logic [5:0] check;
    logic [31:0] data;
  } sea_word_t;

  typedef struct packed {
    logic armed;
    logic [ADDR_W-1:0] start;
    logic [8:0] count;
  } sea_frame_t;

  typedef enum logic [2:0] {
    LNK_CMD = 3'b000,
    LNK_ADDR = 3'b001,
    LNK_READ = 3'b010,
    LNK_WRITE = 3'b011,
    LNK_IGNORE = 3'b100
  } sea_link_state_t;

  typedef enum logic [1:0] {
    PRG_IDLE = 2'b00,
    PRG_ERASE = 2'b01,
    PRG_PROG = 2'b10,
    PRG_HOLD = 2'b11
  } sea_prog_state_t;

  // ==========================================================
  // correction code: data bit j sits at the j-th non power of two
  function automatic logic [5:0] ecc_pos(input int j);
    logic [5:0] r;
    int n;
    r = 6'h00;
    n = 0;
    for (int q = 3; q < 39; q++) begin
      if ((q & (q - 1)) != 0) begin
        if (n == j) r = 6'(q);
        n = n + 1;
      end
    end
    return r;
  endfunction : ecc_pos

  function automatic logic [5:0] ecc_check(input logic [31:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int j = 0; j < 32; j++) begin
      if (d[j]) c = c ^ ecc_pos(j);
    end
    return c;
  endfunction : ecc_check

endpackage : sea_pkg

// file: tb/sea_array_access_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// port checks of the array access block
module sea_array_access_asserts #(
  parameter int unsigned WRITE_CYCLES = 200
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_SCK,
  input wire logic I_CS_N,
  input wire logic I_MOSI,
  input wire logic I_BLOCK_PROTECT_HI,
  input wire logic I_BLOCK_PROTECT_LO,
  input wire logic I_WEL_SET,
  input wire logic I_WEL_CLR,
  input wire logic I_STATUS_WRITE_BUSY,
  input wire logic O_MISO,
  input wire logic O_MISO_OE,
  input wire logic O_WRITE_IN_PROGRESS,
  input wire logic O_WRITE_ENABLE_LATCH
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic [15:0] busy_cnt_q;
  logic busy_frame_q;
  // length of the busy period; a counter, as it is too long to unroll
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) busy_cnt_q <= 16'h0000;
    else if (O_WRITE_IN_PROGRESS) busy_cnt_q <= busy_cnt_q + 16'h0001;
    else busy_cnt_q <= 16'h0000;
  end
  // a frame opened while busy must stay silent to its end
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) busy_frame_q <= 1'h0;
    else if (I_CS_N) busy_frame_q <= 1'h0;
    else if ($fell(I_CS_N) && O_WRITE_IN_PROGRESS) busy_frame_q <= 1'h1;
  end
  a_oe_idle: assert property (I_CS_N |-> !O_MISO_OE)
    else $error("data enable high while deselected");
  a_miso_idle: assert property (I_CS_N |-> !O_MISO)
    else $error("data out not low while deselected");
  a_read_busy: assert property (busy_frame_q |-> !O_MISO_OE)
    else $error("read answered while busy");
  a_status_busy: assert property (
    I_STATUS_WRITE_BUSY |-> O_WRITE_IN_PROGRESS)
    else $error("status write not shown as busy");
  a_reset_clear: assert property ($fell(I_RST) |->
    !O_WRITE_ENABLE_LATCH && O_WRITE_IN_PROGRESS == I_STATUS_WRITE_BUSY)
    else $error("flags not cleared by reset");
  a_latch_set: assert property (I_WEL_SET |=> O_WRITE_ENABLE_LATCH)
    else $error("enable latch not set");
  a_latch_clr: assert property (
    I_WEL_CLR && !I_WEL_SET |=> !O_WRITE_ENABLE_LATCH)
    else $error("enable latch not cleared");
  a_commit_gate: assert property (
    $rose(O_WRITE_IN_PROGRESS) && !I_STATUS_WRITE_BUSY |->
    O_WRITE_ENABLE_LATCH && I_CS_N &&
    !(I_BLOCK_PROTECT_HI && I_BLOCK_PROTECT_LO))
    else $error("write cycle started without leave");
  a_write_time: assert property (
    $fell(O_WRITE_IN_PROGRESS) && !$past(I_STATUS_WRITE_BUSY) |->
    busy_cnt_q >= WRITE_CYCLES - 8 && busy_cnt_q <= WRITE_CYCLES + 2)
    else $error("write cycle length wrong");
  a_latch_done: assert property (
    $fell(O_WRITE_IN_PROGRESS) && !$past(I_STATUS_WRITE_BUSY) |->
    !O_WRITE_ENABLE_LATCH)
    else $error("enable latch kept after write");
  c_read: cover property ($rose(O_MISO_OE));
  c_write: cover property ($rose(O_WRITE_IN_PROGRESS));
  c_busy_frame: cover property (busy_frame_q);
endmodule : sea_array_access_asserts

bind sea_array_access sea_array_access_asserts #(
  .WRITE_CYCLES(WRITE_CYCLES)
) sea_array_access_asserts_i (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_SCK(I_SCK), .I_CS_N(I_CS_N),
  .I_MOSI(I_MOSI), .I_BLOCK_PROTECT_HI(I_BLOCK_PROTECT_HI),
  .I_BLOCK_PROTECT_LO(I_BLOCK_PROTECT_LO), .I_WEL_SET(I_WEL_SET),
  .I_WEL_CLR(I_WEL_CLR), .I_STATUS_WRITE_BUSY(I_STATUS_WRITE_BUSY),
  .O_MISO(O_MISO), .O_MISO_OE(O_MISO_OE),
  .O_WRITE_IN_PROGRESS(O_WRITE_IN_PROGRESS),
  .O_WRITE_ENABLE_LATCH(O_WRITE_ENABLE_LATCH)
);

// file: tb/sea_spi_host.sv
`timescale 1ns/1ps
// ==========================================================
// serial host, mode 0; clock stands low outside frames
module sea_spi_host (
  output logic o_cs_n,
  output logic o_sck,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe,
  output logic [7:0] o_rx,
  output logic o_rx_stb
);
  localparam time HALF = 80ns;
  initial begin
    o_cs_n = 1'h1;
    o_sck = 1'h0;
    o_mosi = 1'h0;
    o_rx = 8'h00;
    o_rx_stb = 1'h0;
  end
  // a falling select opens every frame
  task automatic start();
    #3;
    o_cs_n = 1'h0;
    #HALF;
  endtask : start
  // msb first; data out only counts while the block drives it
  task automatic shift(input logic [7:0] tx, input int n, input bit cap);
    for (int i = 7; i > 7 - n; i--) begin
      o_mosi = tx[i];
      #HALF;
      o_sck = 1'h1;
      o_rx[i] = i_miso_oe ? i_miso : 1'hx;
      #HALF;
      o_sck = 1'h0;
    end
    if (cap) begin
      o_rx_stb = 1'h1;
      #1;
      o_rx_stb = 1'h0;
    end
  endtask : shift
  // deselect after the last fall; released data line flips
  task automatic stop();
    #HALF;
    o_cs_n = 1'h1;
    o_mosi = ~o_mosi;
    #HALF;
  endtask : stop
endmodule : sea_spi_host

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int unsigned WC = 3000;
  logic clk, rst, sck, cs_n, mosi, bp_hi, bp_lo, wel_set, wel_clr, sbusy;
  logic miso, miso_oe, write_in_progress, write_enable_latch, rx_stb;
  logic [7:0] rx;
  logic [7:0] em [int];
  logic [7:0] exp_q [$];
  int error_cnt, n_tests, seed;
  sea_array_access #(.WRITE_CYCLES(WC)) sea_array_access_i (
    .I_CLK(clk), .I_RST(rst), .I_SCK(sck), .I_CS_N(cs_n), .I_MOSI(mosi),
    .I_BLOCK_PROTECT_HI(bp_hi), .I_BLOCK_PROTECT_LO(bp_lo),
    .I_WEL_SET(wel_set), .I_WEL_CLR(wel_clr), .I_STATUS_WRITE_BUSY(sbusy),
    .O_MISO(miso), .O_MISO_OE(miso_oe), .O_WRITE_IN_PROGRESS(write_in_progress),
    .O_WRITE_ENABLE_LATCH(write_enable_latch));
  sea_spi_host sea_spi_host_i (.o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi),
    .i_miso(miso), .i_miso_oe(miso_oe), .o_rx(rx), .o_rx_stb(rx_stb));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask : clks
  // bounded wait; running out ends the run
  task automatic wait_wip(input logic lvl, input int lim);
    int k;
    k = 0;
    while (write_in_progress !== lvl && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (k == lim) begin
      check("wip_wait", 8'(write_in_progress), 8'(lvl));
      conclude();
    end
  endtask : wait_wip
  task automatic pulse(input bit set);
    @(negedge clk);
    if (set) wel_set = 1'h1;
    else wel_clr = 1'h1;
    @(negedge clk);
    wel_set = 1'h0;
    wel_clr = 1'h0;
  endtask : pulse
  // untouched bytes keep the delivery value
  function automatic logic [7:0] ev(input logic [16:0] a);
    return em.exists(a) ? em[a] : 8'hFF;
  endfunction : ev
  task automatic hdr(input logic [7:0] op, input logic [16:0] a);
    sea_spi_host_i.start();
    sea_spi_host_i.shift(op, 8, 1'h0);
    sea_spi_host_i.shift({7'h00, a[16]}, 8, 1'h0);
    sea_spi_host_i.shift(a[15:8], 8, 1'h0);
    sea_spi_host_i.shift(a[7:0], 8, 1'h0);
  endtask : hdr
  // mode 0 refused, 1 taken and finished, 2 taken and left running
  task automatic wr(input logic [16:0] a, input logic [7:0] d[$],
      input int tail, input int mode);
    logic w0;
    hdr(sea_pkg::OP_WRITE, a);
    foreach (d[i]) sea_spi_host_i.shift(d[i], 8, 1'h0);
    if (tail > 0) sea_spi_host_i.shift(8'hA5, tail, 1'h0);
    w0 = write_in_progress;
    sea_spi_host_i.stop();
    if (mode > 0) begin
      foreach (d[i]) em[{a[16:8], a[7:0] + 8'(i)}] = d[i];
      wait_wip(1'h1, 40);
      check("wip_start", 8'(write_in_progress), 8'h01);
      if (mode == 1) wait_wip(1'h0, WC + 40);
      if (mode == 1) check("wel_done", 8'(write_enable_latch), 8'h00);
    end else begin
      clks(40);
      check("wip_refused", 8'(write_in_progress), 8'(w0));
    end
  endtask : wr
  // live reads leave a note per byte; others must stay silent
  task automatic rd(input logic [16:0] a, input int n, input bit live);
    hdr(sea_pkg::OP_READ, a);
    for (int i = 0; i < n; i++) begin
      if (live) exp_q.push_back(ev(a + 17'(i)));
      sea_spi_host_i.shift(8'h00, 8, live);
    end
    check("oe_frame", 8'(miso_oe), 8'(live));
    sea_spi_host_i.stop();
    check("oe_idle", 8'(miso_oe), 8'h00);
  endtask : rd
  // ==========================================================
  // monitor: oldest note against each byte taken in
  always @(posedge rx_stb) begin
    if (exp_q.size() == 0) check("rx_extra", 8'h01, 8'h00);
    else check("rd_byte", rx, exp_q.pop_front());
  end
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'h1;
    wel_set = 1'h0;
    wel_clr = 1'h0;
    bp_hi = 1'h0;
    bp_lo = 1'h0;
    sbusy = 1'h0;
    error_cnt = 0;
    n_tests = 0;
    seed = $urandom(26922);
    repeat (20) @(negedge clk);
    rst = 1'h0;
    clks(4);
    check("wel_rst", 8'(write_enable_latch), 8'h00);
    check("wip_rst", 8'(write_in_progress), 8'h00);
    rd(17'h00000, 4, 1'h1);
    wr(17'h00010, '{8'h3C}, 0, 0);
    pulse(1'h1);
    check("wel_set", 8'(write_enable_latch), 8'h01);
    pulse(1'h0);
    check("wel_clr", 8'(write_enable_latch), 8'h00);
    wr(17'h00010, '{8'h3C}, 0, 0);
    // cut mid-byte with the latch set; latch survives refusal
    pulse(1'h1);
    wr(17'h00020, '{8'h11}, 3, 0);
    // page roll-over, then read and write while busy
    wr(17'h001FE, '{8'h81, 8'h42, 8'h24}, 0, 2);
    rd(17'h00000, 2, 1'h0);
    wr(17'h00030, '{8'h77}, 0, 0);
    wait_wip(1'h0, WC + 40);
    check("wel_end", 8'(write_enable_latch), 8'h00);
    rd(17'h001FC, 4, 1'h1);
    rd(17'h00100, 2, 1'h1);
    rd(17'h00010, 1, 1'h1);
    rd(17'h00020, 1, 1'h1);
    rd(17'h00030, 1, 1'h1);
    // every protection code guards the top page
    for (int c = 1; c < 4; c++) begin
      {bp_hi, bp_lo} = 2'(c);
      pulse(1'h1);
      wr(17'h1FF00, '{8'h5A}, 0, 0);
    end
    {bp_hi, bp_lo} = 2'h0;
    rd(17'h1FF00, 1, 1'h1);
    // random bytes, then a read across the top of the array
    for (int i = 0; i < 2; i++) begin
      pulse(1'h1);
      wr(17'($urandom()), '{8'($urandom())}, 0, 1);
    end
    pulse(1'h1);
    wr(17'h1FFFF, '{8'hC3}, 0, 1);
    rd(17'h1FFFE, 4, 1'h1);
    // read cut short inside a byte, then a clean one
    hdr(sea_pkg::OP_READ, 17'h00100);
    sea_spi_host_i.shift(8'h00, 3, 1'h0);
    sea_spi_host_i.stop();
    check("oe_cut", 8'(miso_oe), 8'h00);
    // one flipped stored bit must still read back as written
    sea_array_access_i.mem_q[15'h0040].data[3] =
      ~sea_array_access_i.mem_q[15'h0040].data[3];
    rd(17'h00100, 1, 1'h1);
    // an outside status write shows as busy and blocks reads
    clks(1);
    sbusy = 1'h1;
    clks(2);
    check("wip_status", 8'(write_in_progress), 8'h01);
    rd(17'h00000, 1, 1'h0);
    clks(1);
    sbusy = 1'h0;
    clks(10);
    check("notes_left", 8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule : testbench
